// ---- inc/aite_pkg.sv ----
// Purpose: shared constants, types and helpers of the analog input timing engine
// Assumes: one 200 MHz clock; all sources sampled in that domain
// Notes: delay fields of zero select the default delays
//
// Contract
// - each sample tick samples every task channel
// - sample tick edge selectable rising or falling
// - internal sample tick: counter, software, divided base
// - external sample tick from terminals, bus, star, comparator
// - routed sample tick active high, pulse or level
// - function terminals are inputs after reset
// - sample ticks ignored outside an acquisition
// - sample ticks ignored while hold gate active
// - begin trigger starts sample counter, stop ends it
// - begin to first sample delay, default two
// - software begin emits begin trigger output pulse
// - posttrigger: load post count, decrement per sample
// - pretrigger: load pre count, then post count
// - stop reference ignored before pre count reached
// - sample base from fast, slow, reference or external
// - sample base edge selectable before division
// - each conversion tick starts exactly one conversion
// - conversion tick edge selectable rising or falling
// - conversion divider starts on sample, reloads, repeats
// - conversion tick internal or external source select
// - routed conversion tick driven active low
// - sample to first conversion delay, default three
// - conversion ticks ignored outside a sample
package aite_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TB_FAST_HZ = 20_000_000;
	localparam int unsigned TB_SLOW_HZ = 100_000;
	localparam int unsigned TB_FAST_CYC = CLK_HZ / TB_FAST_HZ;
	localparam int unsigned TB_SLOW_CYC = CLK_HZ / TB_SLOW_HZ;
	localparam int TB_CNT_W = 11;
	localparam logic [TB_CNT_W-1:0] TB_FAST_LAST = TB_CNT_W'(TB_FAST_CYC - 1);
	localparam logic [TB_CNT_W-1:0] TB_SLOW_LAST = TB_CNT_W'(TB_SLOW_CYC - 1);
	localparam int SAMP_DELAY_DFLT = 2;
	localparam int CONV_DELAY_DFLT = 3;
	// external source vector layout
	localparam int N_TERM = 16;
	localparam int N_BUS = 8;
	localparam int EXT_TERM_LO = 0;
	localparam int EXT_BUS_LO = 16;
	localparam int EXT_STAR = 24;
	localparam int EXT_CMP = 25;
	localparam int EXT_REF10 = 26;
	localparam int EXT_W = 27;
	localparam int IDX_W = 5;
	localparam int N_OUT = N_TERM + N_BUS;

	typedef enum logic [1:0] {BASE_FAST, BASE_SLOW, BASE_REF10, BASE_EXT} aite_base_sel_t;
	typedef enum logic [1:0] {SAMP_DIVIDED, SAMP_COUNTER, SAMP_SOFTWARE, SAMP_EXTERNAL} aite_samp_src_t;
	typedef enum logic [1:0] {CONV_DIVIDED, CONV_COUNTER, CONV_EXTERNAL} aite_conv_src_t;
	typedef enum logic [1:0] {ROUTE_INPUT, ROUTE_SAMPLE, ROUTE_CONVERT, ROUTE_BEGIN} aite_route_t;
	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST} aite_state_t;

	// edge of the selected polarity between two samples
	function automatic logic edge_seen(input logic cur, input logic prev, input logic fall);
		edge_seen = fall ? (prev & ~cur) : (cur & ~prev);
	endfunction : edge_seen

	// edge on one external source picked by index
	function automatic logic ext_edge(input logic [EXT_W-1:0] lvl, input logic [EXT_W-1:0] prev,
		input logic [IDX_W-1:0] idx, input logic fall);
		logic c;
		logic p;
		c = (int'(idx) < EXT_W) ? lvl[idx] : 1'b0;
		p = (int'(idx) < EXT_W) ? prev[idx] : 1'b0;
		ext_edge = edge_seen(c, p, fall);
	endfunction : ext_edge

	// route field of one output pin
	function automatic aite_route_t route_of(input logic [2*N_OUT-1:0] v, input int i);
		route_of = aite_route_t'(v[2*i +: 2]);
	endfunction : route_of
endpackage : aite_pkg

// ---- inc/aite_div_if.sv ----
// Purpose: link between the timing engine and one tick divider
// Assumes: all signals on the engine clock
// Notes: fire is a one-cycle pulse
`timescale 1ns/1ps
interface aite_div_if #(parameter int W = 16);
	logic start;
	logic stop;
	logic tick;
	logic [W-1:0] first_delay;
	logic [W-1:0] period;
	logic fire;
	modport ctrl (output start, output stop, output tick, output first_delay, output period, input fire);
	modport div (input start, input stop, input tick, input first_delay, input period, output fire);
endinterface : aite_div_if

// ---- hdl/aite_divider.sv ----
// Purpose: programmable down-counter that divides a timebase tick
// Assumes: first_delay and period are at least one
// Notes: fire comes one clock after the base tick that ends a count
`timescale 1ns/1ps
module aite_divider #(
	parameter int W = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	aite_div_if.div div_io
);
	logic run_r;
	logic fire_r;
	logic [W-1:0] cnt_r;

	// run flag: start wins over stop
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			run_r <= 1'b0;
		else if (div_io.start)
			run_r <= 1'b1;
		else if (div_io.stop)
			run_r <= 1'b0;
	end

	// count down base ticks, reload after each terminal count
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_r <= '0;
		else if (div_io.start)
			cnt_r <= div_io.first_delay;
		else if (run_r && div_io.tick)
			cnt_r <= (cnt_r <= W'(1)) ? div_io.period : cnt_r - W'(1);
	end

	// one pulse per terminal count
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			fire_r <= 1'b0;
		else
			fire_r <= run_r && !div_io.start && !div_io.stop && div_io.tick && cnt_r <= W'(1);
	end

	assign div_io.fire = fire_r;

	reload_fire_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(run_r && !div_io.start && !div_io.stop && div_io.tick && cnt_r == W'(1))
		|=> (fire_r && cnt_r == $past(div_io.period)))
		else $error("divider missed fire or reload");
endmodule : aite_divider

// ---- hdl/aite_timing_engine.sv ----
// Purpose: sample and conversion tick engine for a multichannel analog input
// Assumes: config inputs are static during an acquisition
// Notes: pins pass three flops; a level counts when stages two and three agree
`timescale 1ns/1ps
module aite_timing_engine #(
	parameter int CNT_W = 24,
	parameter int DIV_W = 16,
	parameter int CH_W = 6
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [aite_pkg::N_TERM-1:0] terminal_in,
	input wire logic [aite_pkg::N_BUS-1:0] trig_bus_in,
	input wire logic star_trig_in,
	input wire logic analog_cmp_in,
	input wire logic ref10_in,
	input wire logic counter_out_in,
	input wire logic sw_begin_in,
	input wire logic sw_stop_in,
	input wire logic sw_sample_pulse_in,
	input wire aite_pkg::aite_base_sel_t base_sel_in,
	input wire logic [aite_pkg::IDX_W-1:0] base_idx_in,
	input wire logic base_falling_in,
	input wire aite_pkg::aite_samp_src_t samp_src_in,
	input wire logic [aite_pkg::IDX_W-1:0] samp_idx_in,
	input wire logic samp_falling_in,
	input wire logic [DIV_W-1:0] samp_delay_in,
	input wire logic [DIV_W-1:0] samp_period_in,
	input wire aite_pkg::aite_conv_src_t conv_src_in,
	input wire logic [aite_pkg::IDX_W-1:0] conv_idx_in,
	input wire logic conv_falling_in,
	input wire logic conv_base_fast_in,
	input wire logic [DIV_W-1:0] conv_delay_in,
	input wire logic [DIV_W-1:0] conv_period_in,
	input wire logic [CH_W-1:0] channel_count_in,
	input wire logic begin_ext_en_in,
	input wire logic [aite_pkg::IDX_W-1:0] begin_idx_in,
	input wire logic begin_falling_in,
	input wire logic pretrig_en_in,
	input wire logic [aite_pkg::IDX_W-1:0] ref_idx_in,
	input wire logic ref_falling_in,
	input wire logic [CNT_W-1:0] pre_count_in,
	input wire logic [CNT_W-1:0] post_count_in,
	input wire logic continuous_in,
	input wire logic hold_en_in,
	input wire logic [aite_pkg::IDX_W-1:0] hold_idx_in,
	input wire logic hold_active_low_in,
	input wire logic sample_level_mode_in,
	input wire logic [2*aite_pkg::N_OUT-1:0] pin_route_in,
	output logic acq_sample_tick_out,
	output logic channel_conversion_tick_out,
	output logic acq_begin_trigger_out,
	output logic acq_active_out,
	output logic pretrig_armed_out,
	output logic [CNT_W-1:0] sample_count_out,
	output logic [aite_pkg::N_TERM-1:0] terminal_out,
	output logic [aite_pkg::N_TERM-1:0] terminal_oe_out,
	output logic [aite_pkg::N_BUS-1:0] trig_bus_out,
	output logic [aite_pkg::N_BUS-1:0] trig_bus_oe_out
);
	import aite_pkg::*;

	logic [EXT_W-1:0] ext_raw;
	logic [EXT_W-1:0] sync1_r, sync2_r, sync3_r, ext_lvl_r, ext_prev_r;
	logic [TB_CNT_W-1:0] fast_cnt_r, slow_cnt_r;
	logic fast_pulse_r, slow_pulse_r, counter_prev_r;
	logic base_tick, conv_base_tick, samp_raw, conv_raw, hold_on;
	logic begin_hit, ref_hit, sample_take, conv_take, conv_last, acq_end, busy_nxt;
	aite_state_t state_r;
	logic active_r, armed_r, conv_busy_r;
	logic [CNT_W-1:0] count_r;
	logic [CH_W-1:0] conv_left_r, chan_eff, conv_seen_r;
	logic samp_tick_r, conv_tick_r, begin_pulse_r;
	logic [N_OUT-1:0] pin_out_r, pin_oe_r;

	aite_div_if #(.W(DIV_W)) samp_div_io ();
	aite_div_if #(.W(DIV_W)) conv_div_io ();

	assign ext_raw = {ref10_in, analog_cmp_in, star_trig_in, trig_bus_in, terminal_in};

	// three-stage synchronisers; the level moves once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < EXT_W; g++)
		begin : g_sync
			always_ff @(posedge ref_clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
					sync3_r[g] <= 1'b0;
					ext_lvl_r[g] <= 1'b0;
					ext_prev_r[g] <= 1'b0;
				end
				else
				begin
					sync1_r[g] <= ext_raw[g];
					sync2_r[g] <= sync1_r[g];
					sync3_r[g] <= sync2_r[g];
					if (sync2_r[g] == sync3_r[g])
						ext_lvl_r[g] <= sync3_r[g];
					ext_prev_r[g] <= ext_lvl_r[g];
				end
			end
		end
	endgenerate

	// 20 MHz and 100 kHz internal timebase pulses
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			fast_cnt_r <= '0;
			slow_cnt_r <= '0;
			fast_pulse_r <= 1'b0;
			slow_pulse_r <= 1'b0;
			counter_prev_r <= 1'b0;
		end
		else
		begin
			fast_cnt_r <= (fast_cnt_r == TB_FAST_LAST) ? '0 : fast_cnt_r + 1'b1;
			slow_cnt_r <= (slow_cnt_r == TB_SLOW_LAST) ? '0 : slow_cnt_r + 1'b1;
			fast_pulse_r <= (fast_cnt_r == TB_FAST_LAST);
			slow_pulse_r <= (slow_cnt_r == TB_SLOW_LAST);
			counter_prev_r <= counter_out_in;
		end
	end

	// source selection for timebase, sample tick and conversion tick
	always_comb
	begin
		case (base_sel_in)
			BASE_FAST: base_tick = fast_pulse_r;
			BASE_SLOW: base_tick = slow_pulse_r;
			BASE_REF10: base_tick = ext_edge(ext_lvl_r, ext_prev_r, IDX_W'(EXT_REF10), base_falling_in);
			default: base_tick = ext_edge(ext_lvl_r, ext_prev_r, base_idx_in, base_falling_in);
		endcase
		conv_base_tick = conv_base_fast_in ? fast_pulse_r : base_tick;
		case (samp_src_in)
			SAMP_DIVIDED: samp_raw = samp_div_io.fire;
			SAMP_COUNTER: samp_raw = edge_seen(counter_out_in, counter_prev_r, samp_falling_in);
			SAMP_SOFTWARE: samp_raw = sw_sample_pulse_in;
			default: samp_raw = ext_edge(ext_lvl_r, ext_prev_r, samp_idx_in, samp_falling_in);
		endcase
		case (conv_src_in)
			CONV_DIVIDED: conv_raw = conv_div_io.fire;
			CONV_COUNTER: conv_raw = edge_seen(counter_out_in, counter_prev_r, conv_falling_in);
			default: conv_raw = ext_edge(ext_lvl_r, ext_prev_r, conv_idx_in, conv_falling_in);
		endcase
	end

	// gating of triggers and ticks
	assign hold_on = hold_en_in && ((((int'(hold_idx_in) < EXT_W) ? ext_lvl_r[hold_idx_in] : 1'b0)) ^ hold_active_low_in);
	assign begin_hit = !active_r && (sw_begin_in || (begin_ext_en_in &&
		ext_edge(ext_lvl_r, ext_prev_r, begin_idx_in, begin_falling_in)));
	assign ref_hit = (state_r == ST_PRE) && armed_r && ext_edge(ext_lvl_r, ext_prev_r, ref_idx_in, ref_falling_in);
	assign sample_take = active_r && !hold_on && !conv_busy_r && samp_raw;
	assign conv_take = conv_busy_r && conv_raw;
	assign conv_last = conv_take && conv_left_r <= CH_W'(1);
	assign chan_eff = (channel_count_in == '0) ? CH_W'(1) : channel_count_in;
	assign acq_end = active_r && (sw_stop_in ||
		((state_r == ST_POST) && sample_take && !continuous_in && count_r <= CNT_W'(1)));
	assign busy_nxt = sample_take || (conv_busy_r && !conv_last);

	// sample divider runs from the begin trigger until the acquisition ends
	assign samp_div_io.start = begin_hit && samp_src_in == SAMP_DIVIDED;
	assign samp_div_io.stop = acq_end;
	assign samp_div_io.tick = base_tick;
	assign samp_div_io.first_delay = (samp_delay_in == '0) ? DIV_W'(SAMP_DELAY_DFLT) : samp_delay_in;
	assign samp_div_io.period = (samp_period_in == '0) ? DIV_W'(1) : samp_period_in;
	aite_divider #(.W(DIV_W)) u_samp_div (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .div_io(samp_div_io));

	// conversion divider restarts on every accepted sample tick
	assign conv_div_io.start = sample_take && conv_src_in == CONV_DIVIDED;
	assign conv_div_io.stop = conv_last;
	assign conv_div_io.tick = conv_base_tick;
	assign conv_div_io.first_delay = (conv_delay_in == '0) ? DIV_W'(CONV_DELAY_DFLT) : conv_delay_in;
	assign conv_div_io.period = (conv_period_in == '0) ? DIV_W'(1) : conv_period_in;
	aite_divider #(.W(DIV_W)) u_conv_div (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .div_io(conv_div_io));

	// acquisition sequencing and sample counter
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= ST_IDLE;
			active_r <= 1'b0;
			armed_r <= 1'b0;
			count_r <= '0;
		end
		else
			case (state_r)
				ST_IDLE:
					if (begin_hit)
					begin
						active_r <= 1'b1;
						if (pretrig_en_in)
						begin
							state_r <= ST_PRE;
							count_r <= pre_count_in;
							armed_r <= (pre_count_in == '0);
						end
						else
						begin
							state_r <= ST_POST;
							count_r <= post_count_in;
						end
					end
				ST_PRE:
					if (acq_end)
					begin
						state_r <= ST_IDLE;
						active_r <= 1'b0;
						armed_r <= 1'b0;
					end
					else if (ref_hit)
					begin
						state_r <= ST_POST;
						count_r <= post_count_in;
						armed_r <= 1'b0;
					end
					else if (sample_take && count_r != '0)
					begin
						count_r <= count_r - CNT_W'(1);
						if (count_r == CNT_W'(1))
							armed_r <= 1'b1;
					end
				ST_POST:
					if (acq_end)
					begin
						state_r <= ST_IDLE;
						active_r <= 1'b0;
						count_r <= '0;
					end
					else if (sample_take && !continuous_in)
						count_r <= count_r - CNT_W'(1);
				default:
				begin
					state_r <= ST_IDLE;
					active_r <= 1'b0;
				end
			endcase
	end

	// per-sample conversion sequencing
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			conv_busy_r <= 1'b0;
			conv_left_r <= '0;
		end
		else if (sample_take)
		begin
			conv_busy_r <= 1'b1;
			conv_left_r <= chan_eff;
		end
		else if (conv_last)
			conv_busy_r <= 1'b0;
		else if (conv_take)
			conv_left_r <= conv_left_r - CH_W'(1);
	end

	// registered tick outputs and pin routing
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			samp_tick_r <= 1'b0;
			conv_tick_r <= 1'b0;
			begin_pulse_r <= 1'b0;
		end
		else
		begin
			samp_tick_r <= sample_take;
			conv_tick_r <= conv_take;
			begin_pulse_r <= begin_hit;
		end
	end

	generate
		for (g = 0; g < N_OUT; g++)
		begin : g_pin
			always_ff @(posedge ref_clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					pin_out_r[g] <= 1'b0;
					pin_oe_r[g] <= 1'b0;
				end
				else
				begin
					pin_oe_r[g] <= route_of(pin_route_in, g) != ROUTE_INPUT;
					case (route_of(pin_route_in, g))
						ROUTE_SAMPLE: pin_out_r[g] <= sample_level_mode_in ? busy_nxt : sample_take;
						ROUTE_CONVERT: pin_out_r[g] <= !conv_take;
						ROUTE_BEGIN: pin_out_r[g] <= begin_hit;
						default: pin_out_r[g] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	assign acq_sample_tick_out = samp_tick_r;
	assign channel_conversion_tick_out = conv_tick_r;
	assign acq_begin_trigger_out = begin_pulse_r;
	assign acq_active_out = active_r;
	assign pretrig_armed_out = armed_r;
	assign sample_count_out = count_r;
	assign terminal_out = pin_out_r[N_TERM-1:0];
	assign terminal_oe_out = pin_oe_r[N_TERM-1:0];
	assign trig_bus_out = pin_out_r[N_OUT-1:N_TERM];
	assign trig_bus_oe_out = pin_oe_r[N_OUT-1:N_TERM];

	// conversions seen since the last accepted sample, for checking only
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			conv_seen_r <= '0;
		else if (sample_take)
			conv_seen_r <= '0;
		else if (conv_take)
			conv_seen_r <= conv_seen_r + CH_W'(1);
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence begin_div_s;
		begin_hit && samp_src_in == SAMP_DIVIDED;
	endsequence
	sequence quiet_two_s;
		!acq_sample_tick_out [*2];
	endsequence

	first_delay_a: assert property (begin_div_s |=> quiet_two_s)
		else $error("sample tick too soon after begin");
	idle_ignore_a: assert property ((!active_r && samp_raw) |=> !acq_sample_tick_out)
		else $error("sample tick passed while idle");
	hold_gate_a: assert property ((hold_on && samp_raw) |=> !acq_sample_tick_out)
		else $error("sample tick passed during hold");
	busy_mask_a: assert property ((conv_busy_r && samp_raw) |=> !acq_sample_tick_out)
		else $error("sample tick passed during conversions");
	conv_count_a: assert property (conv_take |-> conv_seen_r < chan_eff)
		else $error("too many conversions in one sample");
	post_load_a: assert property ((begin_hit && !pretrig_en_in) |=>
		(state_r == ST_POST && count_r == $past(post_count_in)))
		else $error("post count not loaded");
	pre_load_a: assert property ((begin_hit && pretrig_en_in) |=>
		(state_r == ST_PRE && count_r == $past(pre_count_in)))
		else $error("pre count not loaded");
	ref_ignore_a: assert property ((state_r == ST_PRE && !armed_r && !acq_end) |=> state_r == ST_PRE)
		else $error("reference trigger taken before pre count");
	sw_begin_a: assert property ((!active_r && sw_begin_in) |=> (acq_begin_trigger_out && active_r))
		else $error("software begin gave no pulse");
	conv_low_a: assert property ((conv_take && route_of(pin_route_in, 1) == ROUTE_CONVERT)
		|=> (terminal_oe_out[1] && !terminal_out[1]))
		else $error("routed conversion tick not active low");
	pin_input_a: assert property ((route_of(pin_route_in, 2) == ROUTE_INPUT) |=> !terminal_oe_out[2])
		else $error("unrouted terminal is driven");
endmodule : aite_timing_engine

// ---- dv/aite_ext_model.sv ----
// Purpose: far-side model of the counter output and an external sample source pin
// Assumes: one clock; tick inputs are one-cycle pulses from the engine
// Notes: the source pin only moves once a sample's conversions are all done
`timescale 1ns/1ps
module aite_ext_model (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic samp_lvl_in,
	input wire logic [5:0] ch_in,
	input wire logic samp_tick_in,
	input wire logic conv_tick_in,
	output logic cnt_pulse_out,
	output logic samp_pin_out
);
	logic [2:0] div_r;
	logic [7:0] pend_r;
	// counter output toggles every third clock, a rise every six
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_r <= 3'h0;
			cnt_pulse_out <= 1'b0;
		end
		else
		begin
			div_r <= (div_r == 3'h2) ? 3'h0 : div_r + 3'h1;
			if (div_r == 3'h2)
				cnt_pulse_out <= ~cnt_pulse_out;
		end
	end
	// pending conversions hold back any new edge on the source pin
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pend_r <= 8'h00;
			samp_pin_out <= 1'b0;
		end
		else
		begin
			pend_r <= pend_r + (samp_tick_in ? 8'(ch_in) : 8'h00) - (conv_tick_in ? 8'h01 : 8'h00);
			if (pend_r == 8'h00)
				samp_pin_out <= samp_lvl_in;
		end
	end
endmodule : aite_ext_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench of the analog input timing engine
// Assumes: software strobes and plain config ports are the access protocol
// Notes: tick outputs are tallied at each clock edge and compared afterwards
`timescale 1ns/1ps
module testbench;
	import aite_pkg::*;
	logic ref_clk_in = 1'b0, rst_in = 1'b1, samp_lvl = 1'b0;
	logic [N_BUS-1:0] trig_bus_in = 8'h00;
	logic star_trig_in = 1'b0, analog_cmp_in = 1'b0, ref10_in = 1'b0;
	logic sw_begin_in = 1'b0, sw_stop_in = 1'b0, sw_sample_pulse_in = 1'b0;
	wire logic counter_out_in, samp_pin;
	wire logic [N_TERM-1:0] terminal_in = {12'h000, samp_pin, 3'h0};
	aite_base_sel_t base_sel_in = BASE_FAST;
	aite_samp_src_t samp_src_in = SAMP_SOFTWARE;
	aite_conv_src_t conv_src_in = CONV_COUNTER;
	logic [IDX_W-1:0] base_idx_in = 5'h00, samp_idx_in = 5'h03, conv_idx_in = 5'h00;
	logic [IDX_W-1:0] begin_idx_in = 5'h00, ref_idx_in = 5'h11, hold_idx_in = 5'h10;
	logic base_falling_in = 1'b0, samp_falling_in = 1'b0, conv_falling_in = 1'b0, conv_base_fast_in = 1'b1;
	logic begin_ext_en_in = 1'b0, begin_falling_in = 1'b0, pretrig_en_in = 1'b0, ref_falling_in = 1'b0;
	logic continuous_in = 1'b0, hold_en_in = 1'b0, hold_active_low_in = 1'b0, sample_level_mode_in = 1'b0;
	logic [15:0] samp_delay_in = 16'h0000, samp_period_in = 16'h0000;
	logic [15:0] conv_delay_in = 16'h0000, conv_period_in = 16'h0000;
	logic [5:0] channel_count_in = 6'h02;
	logic [23:0] pre_count_in = 24'h000002, post_count_in = 24'h000003;
	logic [47:0] pin_route_in = 48'h000000000009; // pin 0 sample, pin 1 conversion
	logic acq_sample_tick_out, channel_conversion_tick_out, acq_begin_trigger_out;
	logic acq_active_out, pretrig_armed_out;
	logic [23:0] sample_count_out;
	logic [N_TERM-1:0] terminal_out, terminal_oe_out;
	logic [N_BUS-1:0] trig_bus_out, trig_bus_oe_out;
	int fails = 0, num_checks = 0, n_samp = 0, n_conv = 0, n_lo1 = 0, n_hi0 = 0, lat;

	aite_timing_engine i_aite_timing_engine (.ref_clk_in, .rst_in, .terminal_in, .trig_bus_in, .star_trig_in,
		.analog_cmp_in, .ref10_in, .counter_out_in, .sw_begin_in, .sw_stop_in, .sw_sample_pulse_in,
		.base_sel_in, .base_idx_in, .base_falling_in, .samp_src_in, .samp_idx_in, .samp_falling_in,
		.samp_delay_in, .samp_period_in, .conv_src_in, .conv_idx_in, .conv_falling_in, .conv_base_fast_in,
		.conv_delay_in, .conv_period_in, .channel_count_in, .begin_ext_en_in, .begin_idx_in,
		.begin_falling_in, .pretrig_en_in, .ref_idx_in, .ref_falling_in, .pre_count_in, .post_count_in,
		.continuous_in, .hold_en_in, .hold_idx_in, .hold_active_low_in, .sample_level_mode_in,
		.pin_route_in, .acq_sample_tick_out, .channel_conversion_tick_out, .acq_begin_trigger_out,
		.acq_active_out, .pretrig_armed_out, .sample_count_out, .terminal_out, .terminal_oe_out,
		.trig_bus_out, .trig_bus_oe_out);

	aite_ext_model i_aite_ext_model (.ref_clk_in, .rst_in, .samp_lvl_in(samp_lvl), .ch_in(channel_count_in),
		.samp_tick_in(acq_sample_tick_out), .conv_tick_in(channel_conversion_tick_out),
		.cnt_pulse_out(counter_out_in), .samp_pin_out(samp_pin));

	// clock of 5 ns period
	always #2.5 ref_clk_in = ~ref_clk_in;

	// tally ticks and pin activity seen at each edge
	always @(posedge ref_clk_in)
	begin
		if (!rst_in && acq_sample_tick_out === 1'b1)
			n_samp++;
		if (!rst_in && channel_conversion_tick_out === 1'b1)
			n_conv++;
		if (!rst_in && terminal_oe_out[1] === 1'b1 && terminal_out[1] === 1'b0)
			n_lo1++;
		if (!rst_in && terminal_out[0] === 1'b1)
			n_hi0++;
	end

	task step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : step

	// one-cycle software strobe: 0 begin, 1 sample, 2 stop
	task pulse(input int k);
		sw_begin_in = (k == 0);
		sw_sample_pulse_in = (k == 1);
		sw_stop_in = (k == 2);
		step(1);
		sw_begin_in = 1'b0;
		sw_sample_pulse_in = 1'b0;
		sw_stop_in = 1'b0;
	endtask : pulse

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
			fails++;
		end
	endtask : chk

	// bounded wait for a conversion tally
	task wait_conv(input int target);
		int i;
		i = 0;
		while (n_conv < target && i < 200)
		begin
			step(1);
			i++;
		end
	endtask : wait_conv

	task final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// watchdog far beyond the expected run of some 300 cycles
	initial
	begin
		#20000;
		fails++;
		final_report();
	end

	// main sequence
	initial
	begin
		step(16);
		chk("oe_in_reset", 32'h0, {terminal_oe_out, trig_bus_oe_out});
		rst_in = 1'b0;
		step(2);
		chk("term_oe", 32'h3, terminal_oe_out);
		chk("bus_oe", 32'h0, trig_bus_oe_out);
		chk("bus_idle", 32'h0, trig_bus_out);
		chk("pins_idle", 32'h2, terminal_out[1:0]);
		pulse(1);
		step(10);
		chk("idle_sample", 0, n_samp);
		// posttriggered run of three samples, two channels
		pulse(0);
		chk("begin_out", 1, acq_begin_trigger_out);
		chk("post_load", 3, sample_count_out);
		pulse(1);
		step(1);
		pulse(1);
		wait_conv(2);
		step(20);
		chk("pend_mask", 1, n_samp);
		chk("conv_per_sample", 2, n_conv);
		chk("post_dec", 2, sample_count_out);
		chk("conv_pin_low", n_conv, n_lo1);
		chk("samp_pin_high", n_samp, n_hi0);
		hold_en_in = 1'b1;
		trig_bus_in[0] = 1'b1;
		step(8);
		pulse(1);
		step(20);
		chk("hold_mask", 1, n_samp);
		hold_en_in = 1'b0;
		trig_bus_in[0] = 1'b0;
		step(8);
		pulse(1);
		wait_conv(4);
		chk("active_mid", 1, acq_active_out);
		pulse(1);
		wait_conv(6);
		step(2);
		chk("active_end", 0, acq_active_out);
		chk("samples", 3, n_samp);
		// pretriggered run: pre two, post two
		pretrig_en_in = 1'b1;
		post_count_in = 24'h000002;
		pulse(0);
		chk("pre_load", 2, sample_count_out);
		trig_bus_in[1] = 1'b1;
		step(8);
		trig_bus_in[1] = 1'b0;
		step(8);
		chk("ref_early", 0, pretrig_armed_out);
		pulse(1);
		wait_conv(8);
		pulse(1);
		wait_conv(10);
		step(2);
		chk("armed", 1, pretrig_armed_out);
		chk("pre_done", 0, sample_count_out);
		chk("early_ignored", 1, acq_active_out);
		trig_bus_in[1] = 1'b1;
		step(8);
		chk("post_reload", 2, sample_count_out);
		trig_bus_in[1] = 1'b0;
		pulse(2);
		step(2);
		chk("sw_stop", 0, acq_active_out);
		// external terminal source on its falling edge
		pretrig_en_in = 1'b0;
		post_count_in = 24'h000014;
		samp_src_in = SAMP_EXTERNAL;
		samp_falling_in = 1'b1;
		step(1);
		pulse(0);
		samp_lvl = 1'b1;
		step(20);
		chk("rise_ignored", 5, n_samp);
		samp_lvl = 1'b0;
		step(20);
		chk("fall_taken", 6, n_samp);
		wait_conv(12);
		pulse(2);
		step(2);
		// divided fast base, default delays of two sample and three conversion base ticks
		samp_src_in = SAMP_DIVIDED;
		conv_src_in = CONV_DIVIDED;
		step(1);
		pulse(0);
		lat = 0;
		while (acq_sample_tick_out !== 1'b1 && lat < 40)
		begin
			step(1);
			lat++;
		end
		chk("first_div", 1, (lat >= 11 && lat <= 22));
		// first divided conversion lands three fast base ticks after the sample
		lat = 0;
		while (n_conv < 13 && lat < 60)
		begin
			step(1);
			lat++;
		end
		chk("conv_delay", 1, (lat >= 26 && lat <= 36));
		wait_conv(14);
		chk("div_conv", 14, n_conv);
		pulse(2);
		step(2);
		chk("div_stop", 0, acq_active_out);
		final_report();
	end
endmodule : testbench
